// file: include/rsiso_pkg.sv
// Constants and types for the reset and pin-isolation sequencer.
// Assumes a single 50 MHz system clock; machine cycle length is a parameter-free constant here.
package rsiso_pkg;
	// Clock rate and machine cycle
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned CLK_PER_MC = 4; // Oscillator clocks per machine cycle
	// External reset sampling and release; watchdog reset, isolation hold and port settle
	localparam int unsigned EXT_DETECT_MC = 2;
	localparam int unsigned EXT_RELEASE_MC = 2;
	localparam int unsigned WDT_RESET_MC = 2;
	localparam int unsigned ISO_HOLD_MC = 2;
	localparam int unsigned PORT_SETTLE_MC = 2;
	localparam int unsigned EXT_DETECT_CYC = EXT_DETECT_MC * CLK_PER_MC;
	localparam int unsigned EXT_RELEASE_CYC = EXT_RELEASE_MC * CLK_PER_MC;
	localparam int unsigned WDT_RESET_CYC = WDT_RESET_MC * CLK_PER_MC;
	localparam int unsigned ISO_HOLD_CYC = ISO_HOLD_MC * CLK_PER_MC;
	localparam int unsigned PORT_SETTLE_CYC = PORT_SETTLE_MC * CLK_PER_MC;
	// Crystal warm-up after power-on or stop
	localparam int unsigned WARMUP_CLOCKS = 65536;
	localparam int unsigned CNT_W = 17;
	// Reset values
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [7:0] PORT_RESET_VAL = 8'hff;
	localparam logic [1:0] WDT_SEL_SHORTEST = 2'h0;
	localparam logic [7:0] STACK_RESET_VAL = 8'h07;
	localparam logic [2:0] TEST_STRAP_IDLE = 3'h7;
	localparam int unsigned NUM_PORTS = 6;

	typedef enum logic [2:0] {
		RSISO_RUN,
		RSISO_EXT_RESET,
		RSISO_RELEASE,
		RSISO_WARMUP,
		RSISO_WDT_RESET,
		RSISO_ISO_ENTRY,
		RSISO_ISOLATED
	} rsiso_state_t;
endpackage : rsiso_pkg

// file: include/rsiso_sync_if.sv
// Bundle between the sequencer and its pin synchroniser.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface rsiso_sync_if;
	logic ext_reset;
	logic addr_strobe;
	logic prog_strobe;
	logic [2:0] test_strap;
	logic por;
	logic wdt_timeout;
	logic osc_fail;
	logic stop_mode;
	modport sync_side (output ext_reset, addr_strobe, prog_strobe, test_strap, por, wdt_timeout, osc_fail, stop_mode);
	modport seq_side (input ext_reset, addr_strobe, prog_strobe, test_strap, por, wdt_timeout, osc_fail, stop_mode);
endinterface : rsiso_sync_if

// file: core/rsiso_sync.sv
// Two-flop synchronisers for every asynchronous pin or event the sequencer reads.
// Assumes pins are quasi-static compared with the 20 ns clock.
`timescale 1ns/1ps
module rsiso_sync (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ext_reset_i,
	input wire logic addr_strobe_i,
	input wire logic prog_strobe_i,
	input wire logic [2:0] test_strap_i,
	input wire logic por_i,
	input wire logic wdt_timeout_i,
	input wire logic osc_fail_i,
	input wire logic stop_mode_i,
	rsiso_sync_if.sync_side sy
);
	import rsiso_pkg::*;

	typedef struct packed {
		logic [9:0] s1;
		logic [9:0] s2;
	} rsiso_sync_st_t;

	rsiso_sync_st_t st_q;
	rsiso_sync_st_t st_d;

	// First stage feeds only the second stage
	always_comb begin
		st_d = st_q;
		st_d.s1 = {ext_reset_i, addr_strobe_i, prog_strobe_i, test_strap_i, por_i, wdt_timeout_i, osc_fail_i,
			stop_mode_i};
		st_d.s2 = st_q.s1;
	end

	// Straps idle high so a reset exit never sees a false test request
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '{s1: 10'h1f0, s2: 10'h1f0};
		end else begin
			st_q <= st_d;
		end
	end

	assign sy.ext_reset = st_q.s2[9];
	assign sy.addr_strobe = st_q.s2[8];
	assign sy.prog_strobe = st_q.s2[7];
	assign sy.test_strap = st_q.s2[6:4];
	assign sy.por = st_q.s2[3];
	assign sy.wdt_timeout = st_q.s2[2];
	assign sy.osc_fail = st_q.s2[1];
	assign sy.stop_mode = st_q.s2[0];
endmodule : rsiso_sync

// file: core/rsiso_top.sv
// Reset sequencer with in-system pin isolation for a small microcontroller core.
// Assumes pins arrive asynchronously; the power monitor, watchdog and oscillator
// monitor supply level or pulse events; the core obeys core_hold_o and the init pulse.
`timescale 1ns/1ps

module rsiso_top (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ext_reset_i,
	input wire logic addr_strobe_i,
	input wire logic prog_strobe_i,
	input wire logic [2:0] test_strap_i,
	input wire logic por_i,
	input wire logic wdt_timeout_i,
	input wire logic osc_fail_i,
	input wire logic osc_fail_detect_enable_i,
	input wire logic stop_mode_i,
	input wire logic por_flag_clr_i,
	input wire logic wdt_flag_clr_i,
	output logic reset_indicator_n_o,
	output logic core_hold_o,
	output logic core_init_o,
	output logic [15:0] pc_load_o,
	output logic [7:0] stack_ptr_init_o,
	output logic irq_timer_disable_o,
	output logic [1:0] wdt_sel_o,
	output logic [rsiso_pkg::NUM_PORTS*8-1:0] port_latch_set_o,
	output logic port_force_o,
	output logic osc_enable_o,
	output logic pin_isolation_mode_o,
	output logic pin_drive_enable_o,
	output logic test_mode_o,
	output logic por_flag_o,
	output logic watchdog_reset_flag_o,
	output logic ram_clear_o
);
	import rsiso_pkg::*;

	rsiso_sync_if sy ();

	rsiso_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ext_reset_i(ext_reset_i),
		.addr_strobe_i(addr_strobe_i),
		.prog_strobe_i(prog_strobe_i),
		.test_strap_i(test_strap_i),
		.por_i(por_i),
		.wdt_timeout_i(wdt_timeout_i),
		.osc_fail_i(osc_fail_i),
		.stop_mode_i(stop_mode_i),
		.sy(sy)
	);

	typedef struct packed {
		rsiso_state_t state;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] det_cnt;
		logic [CNT_W-1:0] port_cnt;
		logic iso_ok;
		logic osc_fail_detect_enable;
		logic ind_n;
		logic hold;
		logic init;
		logic port_force;
		logic iso;
		logic test;
		logic por_flag;
		logic wdt_flag;
		logic osc_en;
		logic wdt_prev;
		logic drv_en;
	} rsiso_st_t;

	rsiso_st_t st_q;
	rsiso_st_t st_d;

	// Width-safe conversion of package counts
	function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
		cyc = CNT_W'(n);
	endfunction : cyc

	logic wdt_pulse;
	logic osc_fault;
	logic in_reset;

	always_comb begin
		wdt_pulse = sy.wdt_timeout && !st_q.wdt_prev;
		osc_fault = sy.osc_fail && st_q.osc_fail_detect_enable;
		st_d = st_q;
		st_d.init = 1'b0;
		st_d.wdt_prev = sy.wdt_timeout;
		st_d.osc_fail_detect_enable = osc_fail_detect_enable_i;
		st_d.osc_en = 1'b1;

		// External reset detection counter
		if (sy.ext_reset && st_q.state != RSISO_EXT_RESET) begin
			st_d.det_cnt = (st_q.det_cnt == cyc(EXT_DETECT_CYC)) ? st_q.det_cnt : st_q.det_cnt + cyc(1);
		end else begin
			st_d.det_cnt = '0;
		end

		case (st_q.state)
			RSISO_RUN: begin
				st_d.hold = 1'b0;
				if (sy.stop_mode) begin
					st_d.osc_en = 1'b0;
					if (sy.ext_reset) begin
						// Stopped clock: no sampling, go straight to warm-up
						st_d.state = RSISO_WARMUP;
						st_d.cnt = '0;
						st_d.osc_en = 1'b1;
					end
				end else if (st_q.det_cnt == cyc(EXT_DETECT_CYC) - cyc(1) && sy.ext_reset) begin
					st_d.state = RSISO_EXT_RESET;
				end else if (wdt_pulse) begin
					st_d.state = RSISO_WDT_RESET;
					st_d.cnt = '0;
				end
			end
			RSISO_EXT_RESET: begin
				st_d.hold = 1'b1;
				st_d.iso = 1'b0;
				// Isolation request noted while the strobes are posed in reset
				st_d.iso_ok = !sy.addr_strobe && sy.prog_strobe;
				if (!sy.ext_reset) begin
					st_d.test = (sy.test_strap != TEST_STRAP_IDLE);
					st_d.state = st_q.iso_ok ? RSISO_ISO_ENTRY : RSISO_RELEASE;
					st_d.cnt = '0;
				end
			end
			RSISO_RELEASE: begin
				st_d.cnt = st_q.cnt + cyc(1);
				if (st_q.cnt == cyc(EXT_RELEASE_CYC) - cyc(2)) begin
					st_d.state = RSISO_RUN;
					st_d.init = 1'b1;
				end
			end
			RSISO_ISO_ENTRY: begin
				st_d.cnt = st_q.cnt + cyc(1);
				if (sy.addr_strobe || !sy.prog_strobe) begin
					// Strobes let go too early: ordinary start
					st_d.state = RSISO_RUN;
					st_d.init = 1'b1;
				end else if (st_q.cnt == cyc(ISO_HOLD_CYC) - cyc(1)) begin
					st_d.state = RSISO_ISOLATED;
					st_d.iso = 1'b1;
				end
			end
			RSISO_ISOLATED: begin
				st_d.hold = 1'b1;
				// Strobes no longer looked at; only reset brings the part back
				if (st_q.det_cnt == cyc(EXT_DETECT_CYC) - cyc(1) && sy.ext_reset) begin
					st_d.state = RSISO_EXT_RESET;
				end
			end
			RSISO_WARMUP: begin
				st_d.hold = 1'b1;
				st_d.cnt = st_q.cnt + cyc(1);
				if (st_q.cnt == cyc(WARMUP_CLOCKS) - cyc(1)) begin
					st_d.state = sy.ext_reset ? RSISO_EXT_RESET : RSISO_RUN;
					st_d.init = !sy.ext_reset;
				end
			end
			RSISO_WDT_RESET: begin
				st_d.hold = 1'b1;
				st_d.cnt = st_q.cnt + cyc(1);
				if (st_q.cnt == cyc(WDT_RESET_CYC) - cyc(1)) begin
					st_d.state = RSISO_RUN;
					st_d.init = 1'b1;
				end
			end
			default: begin
				st_d.state = RSISO_EXT_RESET;
			end
		endcase

		// Power-on / brownout overrides everything
		if (sy.por) begin
			st_d.state = RSISO_WARMUP;
			st_d.cnt = '0;
			st_d.iso = 1'b0;
			st_d.hold = 1'b1;
		end

		in_reset = (st_d.state == RSISO_EXT_RESET) || (st_d.state == RSISO_WARMUP) ||
			(st_d.state == RSISO_WDT_RESET) || (st_d.state == RSISO_RELEASE) || (st_d.state == RSISO_ISO_ENTRY);
		st_d.hold = in_reset || (st_d.state == RSISO_ISOLATED) || osc_fault;
		st_d.ind_n = !(in_reset || osc_fault);

		// Port force lasts the whole reset; the port_cnt settle count is not used
		if (in_reset) begin
			st_d.port_cnt = (st_q.port_cnt == cyc(PORT_SETTLE_CYC)) ? st_q.port_cnt : st_q.port_cnt + cyc(1);
		end else begin
			st_d.port_cnt = '0;
		end
		// Oscillator failure counts as a reset for the pins as well
		st_d.port_force = in_reset || osc_fault;
		st_d.drv_en = !st_d.iso;

		// Sticky flags: hardware set wins over software clear
		st_d.por_flag = sy.por || (st_q.por_flag && !por_flag_clr_i);
		st_d.wdt_flag = (st_d.state == RSISO_WDT_RESET && st_q.state == RSISO_RUN) ||
			(st_q.wdt_flag && !wdt_flag_clr_i);
	end

	// Power-up state: treat as warm-up in progress
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= '{state: RSISO_WARMUP, cnt: '0, det_cnt: '0, port_cnt: '0, iso_ok: 1'b0, osc_fail_detect_enable: 1'b0,
				ind_n: 1'b0, hold: 1'b1, init: 1'b0, port_force: 1'b1, iso: 1'b0, test: 1'b0,
				por_flag: 1'b1, wdt_flag: 1'b0, osc_en: 1'b1, wdt_prev: 1'b0, drv_en: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register or from package constants
	assign reset_indicator_n_o = st_q.ind_n;
	assign core_hold_o = st_q.hold;
	assign core_init_o = st_q.init;
	assign pc_load_o = RESET_VECTOR;
	assign stack_ptr_init_o = STACK_RESET_VAL;
	assign irq_timer_disable_o = st_q.hold;
	assign wdt_sel_o = WDT_SEL_SHORTEST;
	assign port_latch_set_o = {NUM_PORTS{PORT_RESET_VAL}};
	assign port_force_o = st_q.port_force;
	assign osc_enable_o = st_q.osc_en;
	assign pin_isolation_mode_o = st_q.iso;
	assign pin_drive_enable_o = st_q.drv_en;
	assign test_mode_o = st_q.test;
	assign por_flag_o = st_q.por_flag;
	assign watchdog_reset_flag_o = st_q.wdt_flag;
	// Memories keep contents across any reset
	assign ram_clear_o = 1'b0;
endmodule : rsiso_top

// file: dv/rsiso_properties.sv
// Port-level checks on the reset sequencer.
// Assumes one clock domain; bound onto rsiso_top.
`timescale 1ns/1ps
module rsiso_properties (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ext_reset_i,
	input wire logic addr_strobe_i,
	input wire logic [2:0] test_strap_i,
	input wire logic wdt_timeout_i,
	input wire logic osc_fail_i,
	input wire logic osc_fail_detect_enable_i,
	input wire logic stop_mode_i,
	input wire logic reset_indicator_n_o,
	input wire logic core_hold_o,
	input wire logic [15:0] pc_load_o,
	input wire logic [1:0] wdt_sel_o,
	input wire logic [rsiso_pkg::NUM_PORTS*8-1:0] port_latch_set_o,
	input wire logic port_force_o,
	input wire logic osc_enable_o,
	input wire logic pin_isolation_mode_o,
	input wire logic pin_drive_enable_o,
	input wire logic ram_clear_o
);
	import rsiso_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Watchdog pulse: low for exactly eight clocks
	sequence s_wdt_low;
		##[1:8] $fell(reset_indicator_n_o) ##1 !reset_indicator_n_o [*7] ##1 reset_indicator_n_o;
	endsequence
	// Pin held long enough to be taken
	sequence s_ext_held;
		ext_reset_i [*8] ##1 ext_reset_i [*6];
	endsequence
	a_wdt_width: assert property ($rose(wdt_timeout_i) && !core_hold_o |-> s_wdt_low)
		else $error("watchdog width");
	a_ext_enter: assert property (s_ext_held |-> ##[0:4] !reset_indicator_n_o)
		else $error("ext reset lost");
	a_ext_glitch: assert property ($rose(ext_reset_i) && reset_indicator_n_o && !stop_mode_i
		|=> reset_indicator_n_o [*8]) else $error("reset too early");
	a_ext_release: assert property ($fell(ext_reset_i) && core_hold_o && addr_strobe_i && &test_strap_i
		&& !stop_mode_i && !osc_fail_i |-> ##[1:12] !core_hold_o) else $error("release late");
	a_hold_reset: assert property (!reset_indicator_n_o |-> core_hold_o)
		else $error("runs in reset");
	a_port_force: assert property ($fell(reset_indicator_n_o) |-> ##[0:8] port_force_o && &port_latch_set_o)
		else $error("ports not high");
	a_fixed_vals: assert property (pc_load_o == 16'h0000 && wdt_sel_o == 2'h0 && !ram_clear_o)
		else $error("reset values");
	a_iso_keep: assert property (pin_isolation_mode_o && !ext_reset_i |=>
		pin_isolation_mode_o && !pin_drive_enable_o && osc_enable_o) else $error("isolation lost");
	a_osc_masked: assert property (osc_fail_i && !osc_fail_detect_enable_i && !$past(osc_fail_detect_enable_i)
		&& reset_indicator_n_o && !ext_reset_i && !wdt_timeout_i |=> reset_indicator_n_o) else $error("osc mask");
endmodule : rsiso_properties

bind rsiso_top rsiso_properties u_rsiso_properties (.*);

// file: dv/rsiso_board.sv
// Board reset circuit and tester model: reset pin, strobes, straps.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module rsiso_board (
	input wire logic clk_sys_i,
	output logic ext_reset_o,
	output logic addr_strobe_o,
	output logic prog_strobe_o,
	output logic [2:0] test_strap_o
);
	import rsiso_pkg::*;
	// Idle: reset low, strobes high, straps pulled up
	initial begin
		ext_reset_o = 1'b0;
		addr_strobe_o = 1'b1;
		prog_strobe_o = 1'b1;
		test_strap_o = 3'h7;
	end
	// Reset pulse; strobes and straps kept past release with margin
	task automatic pulse(input int n, input logic iso, input logic [2:0] strap);
		ext_reset_o <= 1'b1;
		addr_strobe_o <= !iso;
		test_strap_o <= strap;
		repeat (n) @(posedge clk_sys_i);
		ext_reset_o <= 1'b0;
		repeat (ISO_HOLD_CYC + 6) @(posedge clk_sys_i);
		addr_strobe_o <= 1'b1;
		test_strap_o <= 3'h7;
	endtask : pulse
endmodule : rsiso_board

// file: dv/tb_rsiso_top.sv
// Self-checking bench for the reset sequencer.
// Assumes a 50 MHz clock; the board model drives the reset pin side.
`timescale 1ns/1ps
module tb_rsiso_top;
	import rsiso_pkg::*;
	logic clk_sys_i, rst_n_i, ext_reset_i, addr_strobe_i, prog_strobe_i, por_i, wdt_timeout_i, osc_fail_i;
	logic osc_fail_detect_enable_i, stop_mode_i, por_flag_clr_i, wdt_flag_clr_i, reset_indicator_n_o, core_hold_o;
	logic core_init_o, irq_timer_disable_o, port_force_o, osc_enable_o, pin_isolation_mode_o, pin_drive_enable_o;
	logic test_mode_o, por_flag_o, watchdog_reset_flag_o, ram_clear_o;
	logic [2:0] test_strap_i;
	logic [15:0] pc_load_o;
	logic [7:0] stack_ptr_init_o;
	logic [1:0] wdt_sel_o;
	logic [NUM_PORTS*8-1:0] port_latch_set_o;
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	rsiso_top u_rsiso_top (.*);
	rsiso_board u_rsiso_board (.clk_sys_i, .ext_reset_o(ext_reset_i), .addr_strobe_o(addr_strobe_i),
		.prog_strobe_o(prog_strobe_i), .test_strap_o(test_strap_i));
	// Clock
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = !clk_sys_i;
	end
	// Hang guard: warm-up plus a few thousand cycles
	initial begin
		repeat (WARMUP_CLOCKS + 6000) @(posedge clk_sys_i);
		error_cnt++;
		test_done;
	end
	task automatic tick(input int c);
		repeat (c) @(posedge clk_sys_i);
	endtask : tick
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Count indicator-low cycles over a span
	task automatic lows(input int m, output int k);
		k = 0;
		repeat (m) begin
			tick(1);
			k += int'(reset_indicator_n_o === 1'b0);
		end
	endtask : lows
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done
	// Stimulus and checks, one scenario after another
	initial begin
		rst_n_i = 1'b0;
		{por_i, wdt_timeout_i, osc_fail_i, osc_fail_detect_enable_i, stop_mode_i, por_flag_clr_i, wdt_flag_clr_i} = '0;
		tick(10);
		rst_n_i <= 1'b1;
		lows(WARMUP_CLOCKS, n);
		chk(n >= WARMUP_CLOCKS - 1, 1);
		tick(20);
		chk({core_hold_o, por_flag_o}, 2'b01);
		por_flag_clr_i <= 1'b1;
		tick(1);
		por_flag_clr_i <= 1'b0;
		fork
			u_rsiso_board.pulse(3, 1'b0, 3'h7);
			lows(15, n);
		join
		chk(n, 0);
		fork
			u_rsiso_board.pulse(30, 1'b0, 3'h7);
			begin
				tick(28);
				chk(core_hold_o && irq_timer_disable_o && !reset_indicator_n_o && port_force_o, 1);
				chk(port_latch_set_o, {NUM_PORTS{8'hff}});
			end
		join
		chk(core_hold_o, 0);
		chk({stack_ptr_init_o, por_flag_o, watchdog_reset_flag_o, ram_clear_o}, {STACK_RESET_VAL, 3'h0});
		$display("ext end");
		wdt_timeout_i <= 1'b1;
		lows(20, n);
		wdt_timeout_i <= 1'b0;
		chk(n, 8);
		chk(watchdog_reset_flag_o, 1);
		wdt_flag_clr_i <= 1'b1;
		tick(1);
		wdt_flag_clr_i <= 1'b0;
		tick(3);
		chk(watchdog_reset_flag_o, 0);
		$display("wdt end");
		osc_fail_i <= 1'b1;
		lows(12, n);
		chk(n, 0);
		osc_fail_detect_enable_i <= 1'b1;
		tick(8);
		chk(!reset_indicator_n_o && core_hold_o, 1);
		osc_fail_i <= 1'b0;
		tick(8);
		osc_fail_detect_enable_i <= 1'b0;
		chk(reset_indicator_n_o, 1);
		$display("osc end");
		u_rsiso_board.pulse(20, 1'b1, 3'h7);
		chk({pin_isolation_mode_o, pin_drive_enable_o, osc_enable_o, reset_indicator_n_o}, 4'hb);
		tick(10);
		chk(pin_isolation_mode_o, 1);
		u_rsiso_board.pulse(20, 1'b0, 3'h7);
		chk({pin_isolation_mode_o, core_hold_o}, 2'b00);
		$display("iso end");
		u_rsiso_board.pulse(20, 1'b0, 3'h5);
		chk(test_mode_o, 1);
		u_rsiso_board.pulse(20, 1'b0, 3'h7);
		chk(test_mode_o, 0);
		$display("strap end");
		stop_mode_i <= 1'b1;
		tick(5);
		chk(osc_enable_o, 0);
		u_rsiso_board.pulse(20, 1'b0, 3'h7);
		tick(1000);
		chk({reset_indicator_n_o, core_hold_o, osc_enable_o}, 3'b011);
		$display("stop end");
		test_done;
	end
endmodule : tb_rsiso_top
